// File: core/led_page1_regs.v
`timescale 1ns/1ps
`include "led_page1_map.vh"
module led_page1_regs #(
  parameter [2:0] CHIP_ID = `CHIP_ID_DEFAULT
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Serial port pins
  input wire sckIn,
  input wire csInN,
  input wire mosiIn,
  output reg misoOut,
  output reg misoOeN,
  // Detection engine
  input wire faultWrite,
  input wire [6:0] faultDot,
  input wire faultFlag,
  output reg openDetectStart,
  output reg shortDetectStart,
  // Thermal comparator pin
  input wire thermalHotIn,
  // Sink current
  input wire [6:0] dotSelect,
  output reg [15:0] dotPeakCurrent,
  output reg [7:0] globalCurrentOut,
  // Matrix control
  output reg runNotShutdown,
  output reg [2:0] activeSwitches,
  output reg sinksOnly,
  output reg phaseDelay180,
  output reg [1:0] switchPulldownMode,
  output reg [2:0] switchPulldownCode,
  output reg [1:0] sinkPullupMode,
  output reg [2:0] sinkPullupCode,
  output reg [1:0] thermalThreshold,
  output reg [1:0] thermalRolloffAmount,
  output reg thermalRolloffActive,
  output reg spreadActive,
  output reg [5:0] spreadRangePct,
  output reg [10:0] spreadCycleUs,
  output reg [2:0] pwmFreqCode,
  output reg [2:0] pwmDivShift
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] dotScale_reg [0:`DOT_COUNT-1];
  reg [3:0] scanSwitchSelect_reg;
  reg [1:0] faultDetectRequest_reg;
  reg runNotShutdown_reg;
  reg [7:0] globalCurrentValue_reg;
  reg phaseDelaySelect_reg;
  reg [2:0] switchPulldownSelect_reg;
  reg [2:0] sinkPullupSelect_reg;
  reg [3:0] thermal_reg;
  reg [4:0] spread_reg;
  reg pwmFreqChangeEnable_reg;
  reg [2:0] pwmFreqCode_reg;
  reg [`DOT_COUNT-1:0] faultFlags_reg;

  // Serial engine state
  reg [2:0] bitCnt_reg;
  reg [1:0] byteCnt_reg;
  reg [6:0] shiftIn_reg;
  reg [7:0] command_reg;
  reg [7:0] addr_reg;
  reg [7:0] txShift_reg;
  reg wrStrobe_reg;
  reg [7:0] wrAddr_reg;
  reg [7:0] wrData_reg;

  wire [2:0] pinLevel;
  wire [2:0] pinRise;
  wire [2:0] pinFall;
  wire sckRise = pinRise[0];
  wire sckFall = pinFall[0];
  wire csIdle = ~pinLevel[1];
  wire mosiBit = pinLevel[2];
  wire [7:0] cfgDefault = `RST_CONFIG;
  wire [7:0] rxByte = {shiftIn_reg, mosiBit};
  wire [7:0] addrNext = addr_reg + 8'h01;
  wire chipSelected = (command_reg[`CMD_ID_HI:`CMD_ID_LO] == CHIP_ID) &&
    (command_reg[`CMD_PAGE_HI:`CMD_PAGE_LO] == `PAGE_FUNCTION);
  wire isRead = command_reg[`CMD_RW_BIT];
  wire [7:0] scaleIdx = wrAddr_reg - `ADDR_SCALE_FIRST;
  wire [1:0] newDetect = wrData_reg[`CFG_DET_HI:`CFG_DET_LO];

  integer k;

  sync_edge #(
    .WIDTH(3)
  ) uPinSync (
    .clk(clk),
    .rst(rst),
    .asyncIn({mosiIn, ~csInN, sckIn}), // Select inverted so the reset level reads as idle
    .levelOut(pinLevel),
    .riseOut(pinRise),
    .fallOut(pinFall)
  );

  // Thermal pin through its own two stages
  reg hotMeta_reg;
  reg hotSync_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hotMeta_reg <= 1'b0;
      hotSync_reg <= 1'b0;
    end else begin
      hotMeta_reg <= thermalHotIn;
      hotSync_reg <= hotMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer, used for first and auto-incremented reads
  function [7:0] readByte;
    input [7:0] a;
    reg [7:0] sIdx;
    reg [3:0] fIdx;
    begin
      sIdx = a - `ADDR_SCALE_FIRST;
      fIdx = a[3:0] - 4'h3;
      readByte = 8'h00;
      if (a >= `ADDR_SCALE_FIRST && a <= `ADDR_SCALE_LAST) begin
        readByte = dotScale_reg[sIdx[6:0]];
      end else if (a == `ADDR_CONFIG) begin
        readByte = {scanSwitchSelect_reg, 1'b0, faultDetectRequest_reg, runNotShutdown_reg};
      end else if (a == `ADDR_GLOBAL_CURRENT) begin
        readByte = globalCurrentValue_reg;
      end else if (a == `ADDR_PULL_PHASE) begin
        readByte = {phaseDelaySelect_reg, switchPulldownSelect_reg, 1'b0, sinkPullupSelect_reg};
      end else if (a >= `ADDR_FAULT_FIRST && a <= `ADDR_FAULT_LAST) begin
        readByte = {2'b00, faultFlags_reg[fIdx*`SINKS_PER_FAULT_REG +: `SINKS_PER_FAULT_REG]};
      end else if (a == `ADDR_THERMAL) begin
        readByte = {4'h0, thermal_reg};
      end else if (a == `ADDR_SPREAD) begin
        readByte = {3'b000, spread_reg};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Serial engine: capture on clock rise, shift out on clock fall
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 2'h0;
      shiftIn_reg <= 7'h00;
      command_reg <= 8'h00;
      addr_reg <= 8'h00;
      txShift_reg <= 8'h00;
      wrStrobe_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      wrData_reg <= 8'h00;
      misoOut <= 1'b0;
      misoOeN <= 1'b1;
    end else begin
      wrStrobe_reg <= 1'b0;
      if (csIdle) begin
        bitCnt_reg <= 3'h0;
        byteCnt_reg <= 2'h0;
        misoOeN <= 1'b1;
      end else if (sckRise) begin
        shiftIn_reg <= rxByte[6:0];
        bitCnt_reg <= bitCnt_reg + 3'h1;
        if (bitCnt_reg == 3'h7) begin
          if (byteCnt_reg != 2'h2) begin
            byteCnt_reg <= byteCnt_reg + 2'h1;
          end
          if (byteCnt_reg == 2'h0) begin
            command_reg <= rxByte;
          end else if (byteCnt_reg == 2'h1) begin
            addr_reg <= rxByte;
            txShift_reg <= readByte(rxByte);
            if (isRead && chipSelected) begin
              misoOeN <= 1'b0;
            end
          end else begin
            addr_reg <= addrNext;
            txShift_reg <= readByte(addrNext);
            if (!isRead && chipSelected) begin
              wrStrobe_reg <= 1'b1;
              wrAddr_reg <= addr_reg;
              wrData_reg <= rxByte;
            end
          end
        end
      end else if (sckFall) begin
        misoOut <= txShift_reg[7];
        txShift_reg <= {txShift_reg[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file
  task loadDefaults;
    begin
      for (k = 0; k < `DOT_COUNT; k = k + 1) begin
        dotScale_reg[k] <= `RST_SCALE;
      end
      scanSwitchSelect_reg <= cfgDefault[`CFG_SCAN_HI:`CFG_SCAN_LO];
      faultDetectRequest_reg <= cfgDefault[`CFG_DET_HI:`CFG_DET_LO];
      runNotShutdown_reg <= cfgDefault[`CFG_RUN];
      globalCurrentValue_reg <= `RST_GLOBAL_CURRENT;
      phaseDelaySelect_reg <= `RST_PHASE;
      switchPulldownSelect_reg <= `RST_SW_PULLDOWN;
      sinkPullupSelect_reg <= `RST_SINK_PULLUP;
      thermal_reg <= `RST_THERMAL;
      spread_reg <= `RST_SPREAD;
      pwmFreqChangeEnable_reg <= `RST_PWM_UNLOCK;
      pwmFreqCode_reg <= `RST_PWM_CODE;
      faultFlags_reg <= {`DOT_COUNT{1'b0}};
    end
  endtask

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      loadDefaults;
      openDetectStart <= 1'b0;
      shortDetectStart <= 1'b0;
    end else begin
      openDetectStart <= 1'b0;
      shortDetectStart <= 1'b0;
      if (wrStrobe_reg && wrAddr_reg == `ADDR_SOFT_RESET && wrData_reg == `SOFT_RESET_KEY) begin
        loadDefaults;
      end else begin
        if (wrStrobe_reg) begin
          if (wrAddr_reg >= `ADDR_SCALE_FIRST && wrAddr_reg <= `ADDR_SCALE_LAST) begin
            dotScale_reg[scaleIdx[6:0]] <= wrData_reg;
          end else if (wrAddr_reg == `ADDR_CONFIG) begin
            scanSwitchSelect_reg <= wrData_reg[`CFG_SCAN_HI:`CFG_SCAN_LO];
            faultDetectRequest_reg <= newDetect;
            runNotShutdown_reg <= wrData_reg[`CFG_RUN];
            // Only a step up from idle fires the one-off detection
            if (faultDetectRequest_reg == `DET_NONE && newDetect == `DET_OPEN) begin
              openDetectStart <= 1'b1;
            end
            if (faultDetectRequest_reg == `DET_NONE && newDetect == `DET_SHORT) begin
              shortDetectStart <= 1'b1;
            end
          end else if (wrAddr_reg == `ADDR_GLOBAL_CURRENT) begin
            globalCurrentValue_reg <= wrData_reg;
          end else if (wrAddr_reg == `ADDR_PULL_PHASE) begin
            phaseDelaySelect_reg <= wrData_reg[`PULL_PHASE];
            switchPulldownSelect_reg <= wrData_reg[`PULL_SW_HI:`PULL_SW_LO];
            sinkPullupSelect_reg <= wrData_reg[`PULL_CS_HI:`PULL_CS_LO];
          end else if (wrAddr_reg == `ADDR_THERMAL) begin
            thermal_reg <= wrData_reg[3:0];
          end else if (wrAddr_reg == `ADDR_SPREAD) begin
            spread_reg <= wrData_reg[4:0];
          end else if (wrAddr_reg == `ADDR_PWM_UNLOCK) begin
            pwmFreqChangeEnable_reg <= wrData_reg[`PF_EN_BIT];
          end else if (wrAddr_reg == `ADDR_PWM_FREQ && pwmFreqChangeEnable_reg) begin
            pwmFreqCode_reg <= wrData_reg[`PF_CODE_HI:`PF_CODE_LO];
          end
        end
      end
      // Dots scaled to zero keep their last result; a result beside a soft reset still lands
      if (faultWrite && faultDot < `DOT_COUNT && dotScale_reg[faultDot] != 8'h00) begin
        faultFlags_reg[faultDot] <= faultFlag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded controls toward the analog and scan logic
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dotPeakCurrent <= 16'h0000;
      globalCurrentOut <= 8'h00;
      runNotShutdown <= 1'b0;
      activeSwitches <= 3'h4;
      sinksOnly <= 1'b0;
      phaseDelay180 <= 1'b0;
      switchPulldownMode <= 2'h1;
      switchPulldownCode <= `RST_SW_PULLDOWN;
      sinkPullupMode <= 2'h1;
      sinkPullupCode <= `RST_SINK_PULLUP;
      thermalThreshold <= 2'h0;
      thermalRolloffAmount <= 2'h0;
      thermalRolloffActive <= 1'b0;
      spreadActive <= 1'b0;
      spreadRangePct <= `SPREAD_PCT_0;
      spreadCycleUs <= `SPREAD_US_0;
      pwmFreqCode <= `RST_PWM_CODE;
      pwmDivShift <= 3'h0;
    end else begin
      // Shutdown forces zero sink current
      if (runNotShutdown_reg && dotSelect < `DOT_COUNT) begin
        dotPeakCurrent <= {8'h00, globalCurrentValue_reg} * {8'h00, dotScale_reg[dotSelect]};
      end else begin
        dotPeakCurrent <= 16'h0000;
      end
      globalCurrentOut <= globalCurrentValue_reg;
      runNotShutdown <= runNotShutdown_reg;
      case (scanSwitchSelect_reg)
        `SCAN_THREE: begin
          activeSwitches <= 3'h3;
          sinksOnly <= 1'b0;
        end
        `SCAN_TWO: begin
          activeSwitches <= 3'h2;
          sinksOnly <= 1'b0;
        end
        `SCAN_NONE: begin
          activeSwitches <= 3'h0;
          sinksOnly <= 1'b1;
        end
        default: begin
          activeSwitches <= 3'h4;
          sinksOnly <= 1'b0;
        end
      endcase
      phaseDelay180 <= phaseDelaySelect_reg;
      // Mode 0 none, 1 off time only, 2 always
      switchPulldownMode <= (switchPulldownSelect_reg == 3'h0) ? 2'h0 :
        (switchPulldownSelect_reg[2] ? 2'h2 : 2'h1);
      switchPulldownCode <= switchPulldownSelect_reg;
      sinkPullupMode <= (sinkPullupSelect_reg == 3'h0) ? 2'h0 :
        (sinkPullupSelect_reg[2] ? 2'h2 : 2'h1);
      sinkPullupCode <= sinkPullupSelect_reg;
      thermalThreshold <= thermal_reg[3:2];
      thermalRolloffAmount <= thermal_reg[1:0];
      thermalRolloffActive <= hotSync_reg;
      spreadActive <= spread_reg[`SPREAD_EN];
      case (spread_reg[3:2])
        2'h0: spreadRangePct <= `SPREAD_PCT_0;
        2'h1: spreadRangePct <= `SPREAD_PCT_1;
        2'h2: spreadRangePct <= `SPREAD_PCT_2;
        default: spreadRangePct <= `SPREAD_PCT_3;
      endcase
      case (spread_reg[1:0])
        2'h0: spreadCycleUs <= `SPREAD_US_0;
        2'h1: spreadCycleUs <= `SPREAD_US_1;
        2'h2: spreadCycleUs <= `SPREAD_US_2;
        default: spreadCycleUs <= `SPREAD_US_3;
      endcase
      pwmFreqCode <= pwmFreqCode_reg;
      // Divide-by-two steps from full rate
      pwmDivShift <= (pwmFreqCode_reg == `PF_CODE_ALIAS) ? 3'h0 : pwmFreqCode_reg;
    end
  end

endmodule // led_page1_regs

// File: core/led_page1_map.vh
`ifndef LED_PAGE1_MAP_VH
`define LED_PAGE1_MAP_VH

////////////////////////////////////////////////////////////////////////
// Command byte layout
`define CMD_RW_BIT 7
`define CMD_ID_HI 6
`define CMD_ID_LO 4
`define CMD_PAGE_HI 3
`define CMD_PAGE_LO 0
`define PAGE_FUNCTION 4'h1
`define CHIP_ID_DEFAULT 3'h4

////////////////////////////////////////////////////////////////////////
// Register offsets
`define ADDR_SCALE_FIRST 8'h01
`define ADDR_SCALE_LAST 8'h48
`define ADDR_CONFIG 8'h50
`define ADDR_GLOBAL_CURRENT 8'h51
`define ADDR_PULL_PHASE 8'h52
`define ADDR_FAULT_FIRST 8'h53
`define ADDR_FAULT_LAST 8'h5E
`define ADDR_THERMAL 8'h5F
`define ADDR_SPREAD 8'h60
`define ADDR_SOFT_RESET 8'h8F
`define ADDR_PWM_UNLOCK 8'hE0
`define ADDR_PWM_FREQ 8'hE2

////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_SCALE 8'h00
`define RST_CONFIG 8'h00
`define RST_GLOBAL_CURRENT 8'h00
`define RST_PHASE 1'h0
`define RST_SW_PULLDOWN 3'h3
`define RST_SINK_PULLUP 3'h3
`define RST_THERMAL 4'h0
`define RST_SPREAD 5'h00
`define RST_PWM_UNLOCK 1'h0
`define RST_PWM_CODE 3'h0
`define SOFT_RESET_KEY 8'hAE

////////////////////////////////////////////////////////////////////////
// Field positions
`define CFG_SCAN_HI 7
`define CFG_SCAN_LO 4
`define CFG_DET_HI 2
`define CFG_DET_LO 1
`define CFG_RUN 0
`define PULL_PHASE 7
`define PULL_SW_HI 6
`define PULL_SW_LO 4
`define PULL_CS_HI 2
`define PULL_CS_LO 0
`define SPREAD_EN 4
`define PF_EN_BIT 0
`define PF_CODE_HI 7
`define PF_CODE_LO 5

////////////////////////////////////////////////////////////////////////
// Encodings and figures
`define DET_NONE 2'h0
`define DET_OPEN 2'h1
`define DET_SHORT 2'h2
`define SCAN_FOUR 4'h0
`define SCAN_THREE 4'h1
`define SCAN_TWO 4'h2
`define SCAN_NONE 4'h3
`define SPREAD_PCT_0 6'h05
`define SPREAD_PCT_1 6'h0F
`define SPREAD_PCT_2 6'h18
`define SPREAD_PCT_3 6'h22
`define SPREAD_US_0 11'h7BC
`define SPREAD_US_1 11'h4B0
`define SPREAD_US_2 11'h334
`define SPREAD_US_3 11'h294
`define PF_CODE_ALIAS 3'h7
`define DOT_COUNT 72
`define SINKS_PER_FAULT_REG 6

`endif

// File: core/sync_edge.v
`timescale 1ns/1ps
module sync_edge #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Asynchronous inputs
  input wire [WIDTH-1:0] asyncIn,
  // Synchronised level and edge pulses
  output reg [WIDTH-1:0] levelOut,
  output wire [WIDTH-1:0] riseOut,
  output wire [WIDTH-1:0] fallOut
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
          levelOut[i] <= 1'b0;
        end else begin
          stage1_reg[i] <= asyncIn[i];
          stage2_reg[i] <= stage1_reg[i];
          levelOut[i] <= stage2_reg[i];
        end
      end
      assign riseOut[i] = stage2_reg[i] & ~levelOut[i];
      assign fallOut[i] = ~stage2_reg[i] & levelOut[i];
    end
  endgenerate

endmodule // sync_edge

// File: verification/led_page1_regs_checker.sv
`timescale 1ns/1ps
module led_page1_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic csInN,
  input wire logic misoOeN,
  input wire logic openDetectStart,
  input wire logic shortDetectStart,
  input wire logic thermalHotIn,
  input wire logic thermalRolloffActive,
  input wire logic runNotShutdown,
  input wire logic sinksOnly,
  input wire logic [6:0] dotSelect,
  input wire logic [15:0] dotPeakCurrent,
  input wire logic [2:0] activeSwitches,
  input wire logic [1:0] switchPulldownMode,
  input wire logic [2:0] switchPulldownCode,
  input wire logic [1:0] sinkPullupMode,
  input wire logic [2:0] sinkPullupCode,
  input wire logic [2:0] pwmFreqCode,
  input wire logic [2:0] pwmDivShift
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_oe_idle; csInN [*6] |-> misoOeN; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
  property p_open_once; openDetectStart |=> !openDetectStart; endproperty
  a_open_once: assert property (p_open_once) else $error("open start longer than one cycle");
  property p_short_once; shortDetectStart |=> !shortDetectStart; endproperty
  a_short_once: assert property (p_short_once) else $error("short start longer than one cycle");
  property p_det_excl; !(openDetectStart && shortDetectStart); endproperty
  a_det_excl: assert property (p_det_excl) else $error("open and short started together");
  property p_scan; (sinksOnly == (activeSwitches == 3'h0)) && activeSwitches != 3'h1; endproperty
  a_scan: assert property (p_scan) else $error("scan outputs disagree");
  property p_pulldown;
    switchPulldownMode == (switchPulldownCode == 3'h0 ? 2'h0 : switchPulldownCode[2] ? 2'h2 : 2'h1);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down mode wrong");
  property p_pullup;
    sinkPullupMode == (sinkPullupCode == 3'h0 ? 2'h0 : sinkPullupCode[2] ? 2'h2 : 2'h1);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up mode wrong");
  property p_div;
    pwmDivShift == ((pwmFreqCode == 3'h0 || pwmFreqCode == 3'h7) ? 3'h0 : pwmFreqCode);
  endproperty
  a_div: assert property (p_div) else $error("frequency divide wrong");
  property p_shutdown; !runNotShutdown && $past(!runNotShutdown) |-> dotPeakCurrent == 16'h0; endproperty
  a_shutdown: assert property (p_shutdown) else $error("current while shut down");
  property p_range; dotSelect >= 7'h48 |=> dotPeakCurrent == 16'h0; endproperty
  a_range: assert property (p_range) else $error("current for missing dot");
  property p_thermal; thermalHotIn [*5] |-> thermalRolloffActive; endproperty
  a_thermal: assert property (p_thermal) else $error("roll-off not flagged");
  c_open: cover property (openDetectStart);
  c_short: cover property (shortDetectStart);
  c_read: cover property (!misoOeN);
  c_hot: cover property (thermalRolloffActive);
endmodule // led_page1_regs_checker

bind led_page1_regs led_page1_regs_checker i_led_page1_regs_checker (.clk, .rst, .csInN, .misoOeN,
  .openDetectStart, .shortDetectStart, .thermalHotIn, .thermalRolloffActive, .runNotShutdown, .sinksOnly,
  .dotSelect, .dotPeakCurrent, .activeSwitches, .switchPulldownMode, .switchPulldownCode, .sinkPullupMode,
  .sinkPullupCode, .pwmFreqCode, .pwmDivShift);

// File: verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Serial pins
  output logic sckIn,
  output logic csInN,
  output logic mosiIn,
  input wire logic misoOut,
  input wire logic misoOeN
);
  initial begin
    sckIn = 1'b0;
    csInN = 1'b1;
    mosiIn = 1'b0;
  end
  ////////////////////////////////////////
  // One byte, MSB first; released miso reads as pulled high
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosiIn = tx[i];
      #120 sckIn = 1'b1;
      rx[i] = misoOeN ? 1'b1 : misoOut;
      #80 sckIn = 1'b0;
    end
  endtask
  // Command byte, address byte, then n data bytes
  task automatic frame(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input int n,
                       output logic [7:0] q);
    logic [7:0] r;
    csInN = 1'b0;
    xb(c, r);
    xb(a, r);
    repeat (n) xb(d, q);
    #120 csInN = 1'b1;
    mosiIn = ~mosiIn;
    #200;
  endtask
endmodule // spi_host_model

// File: verification/led_page1_regs_bench.sv
`timescale 1ns/1ps
module led_page1_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic faultWrite = 1'b0;
  logic faultFlag = 1'b0;
  logic thermalHotIn = 1'b0;
  logic [6:0] faultDot = 7'h00;
  logic [6:0] dotSelect = 7'h00;
  logic sckIn, csInN, mosiIn, misoOut, misoOeN, openDetectStart, shortDetectStart, runNotShutdown;
  logic sinksOnly, phaseDelay180, thermalRolloffActive, spreadActive;
  logic [15:0] dotPeakCurrent;
  logic [7:0] globalCurrentOut, q;
  logic [2:0] activeSwitches, switchPulldownCode, sinkPullupCode, pwmFreqCode, pwmDivShift;
  logic [1:0] switchPulldownMode, sinkPullupMode, thermalThreshold, thermalRolloffAmount;
  logic [5:0] spreadRangePct;
  logic [10:0] spreadCycleUs;
  logic [5:0] pct [4] = '{6'h05, 6'h0F, 6'h18, 6'h22};
  logic [10:0] us [4] = '{11'h7BC, 11'h4B0, 11'h334, 11'h294};
  int numErrors = 0;
  int checkCount = 0;
  int openCnt = 0;
  int shortCnt = 0;
  localparam logic [7:0] WR = 8'h41;
  localparam logic [7:0] RD = 8'hC1;

  always #12.5 clk = ~clk;

  led_page1_regs i_led_page1_regs (.clk, .rst, .sckIn, .csInN, .mosiIn, .misoOut, .misoOeN, .faultWrite,
    .faultDot, .faultFlag, .openDetectStart, .shortDetectStart, .thermalHotIn, .dotSelect, .dotPeakCurrent,
    .globalCurrentOut, .runNotShutdown, .activeSwitches, .sinksOnly, .phaseDelay180, .switchPulldownMode,
    .switchPulldownCode, .sinkPullupMode, .sinkPullupCode, .thermalThreshold, .thermalRolloffAmount,
    .thermalRolloffActive, .spreadActive, .spreadRangePct, .spreadCycleUs, .pwmFreqCode, .pwmDivShift);
  spi_host_model i_spi_host_model (.sckIn, .csInN, .mosiIn, .misoOut, .misoOeN);

  always @(posedge clk) begin
    if (openDetectStart === 1'b1) openCnt++;
    if (shortDetectStart === 1'b1) shortCnt++;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checkCount++;
    if (s !== e) begin
      numErrors++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_spi_host_model.frame(WR, a, d, 1, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_spi_host_model.frame(RD, a, 8'h00, 1, q);
    chk(q, e);
  endtask
  function automatic logic [1:0] md(input logic [2:0] c);
    return c == 3'h0 ? 2'h0 : c[2] ? 2'h2 : 2'h1;
  endfunction
  ////////////////////////////////////////
  task automatic t_defaults;
    rdc(8'h50, 8'h00);
    rdc(8'h51, 8'h00);
    rdc(8'h52, 8'h33);
    rdc(8'h5F, 8'h00);
    rdc(8'h60, 8'h00);
    rdc(8'h01, 8'h00);
    rdc(8'h5E, 8'h00);
    chk(spreadCycleUs, 11'h7BC);
  endtask
  task automatic t_burst;
    i_spi_host_model.frame(WR, 8'h47, 8'hA5, 2, q);
    rdc(8'h48, 8'hA5);
    i_spi_host_model.frame(RD, 8'h46, 8'h00, 2, q);
    chk(q, 8'hA5);
  endtask
  task automatic t_scan;
    for (int i = 0; i < 5; i++) begin
      wr(8'h50, {i[3:0], 4'h0});
      chk(activeSwitches, i == 3 ? 3'h0 : i == 1 ? 3'h3 : i == 2 ? 3'h2 : 3'h4);
      chk(sinksOnly, i == 3);
    end
  endtask
  task automatic t_pull;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], 1'b1, ~i[2:0]};
      wr(8'h52, v);
      rdc(8'h52, v & 8'hF7);
      chk(phaseDelay180, i[0]);
      chk(switchPulldownMode, md(i[2:0]));
      chk(sinkPullupMode, md(~i[2:0]));
      chk(switchPulldownCode, v[6:4]);
      chk(sinkPullupCode, v[2:0]);
    end
  endtask
  task automatic t_spread;
    for (int i = 0; i < 4; i++) begin
      wr(8'h60, {3'h0, i[0], i[1:0], i[1:0]});
      chk(spreadActive, i[0]);
      chk(spreadRangePct, pct[i]);
      chk(spreadCycleUs, us[i]);
    end
    wr(8'h60, 8'hFF);
    rdc(8'h60, 8'h1F);
  endtask
  task automatic t_current;
    wr(8'h51, 8'hC8);
    wr(8'h05, 8'h3F);
    wr(8'h50, 8'h00);
    @(negedge clk) dotSelect = 7'h04;
    chk(globalCurrentOut, 8'hC8);
    chk(dotPeakCurrent, 16'h0000);
    chk(runNotShutdown, 1'b0);
    wr(8'h50, 8'h01);
    chk(runNotShutdown, 1'b1);
    chk(dotPeakCurrent, 16'h3138);
    @(negedge clk) dotSelect = 7'h48;
    repeat (2) @(negedge clk);
    chk(dotPeakCurrent, 16'h0000);
  endtask
  task automatic t_detect;
    wr(8'h51, 8'h20);
    wr(8'h52, 8'h00);
    wr(8'h50, 8'h03);
    wr(8'h50, 8'h03);
    chk(openCnt, 1);
    wr(8'h50, 8'h05);
    chk(shortCnt, 0);
    wr(8'h50, 8'h01);
    wr(8'h50, 8'h05);
    chk(shortCnt, 1);
    wr(8'h08, 8'h10);
    @(negedge clk);
    faultDot = 7'h07;
    faultFlag = 1'b1;
    faultWrite = 1'b1;
    @(negedge clk) faultDot = 7'h06;
    @(negedge clk) faultWrite = 1'b0;
    rdc(8'h54, 8'h02);
    wr(8'h54, 8'hFF);
    rdc(8'h54, 8'h02);
  endtask
  task automatic t_freq;
    wr(8'hE2, 8'h60);
    chk(pwmFreqCode, 3'h0);
    wr(8'hE0, 8'h01);
    wr(8'hE2, 8'h60);
    chk(pwmDivShift, 3'h3);
    wr(8'hE2, 8'hE0);
    chk(pwmDivShift, 3'h0);
  endtask
  task automatic t_reset;
    wr(8'h8F, 8'h55);
    rdc(8'h51, 8'h20);
    i_spi_host_model.frame(8'h01, 8'h51, 8'h77, 1, q);
    rdc(8'h51, 8'h20);
    i_spi_host_model.frame(8'h81, 8'h51, 8'h00, 1, q);
    chk(q, 8'hFF);
    rdc(8'h70, 8'h00);
    wr(8'h8F, 8'hAE);
    rdc(8'h51, 8'h00);
    rdc(8'h52, 8'h33);
    rdc(8'h54, 8'h00);
    chk(pwmFreqCode, 3'h0);
  endtask
  task automatic t_thermal;
    wr(8'h5F, 8'hFF);
    rdc(8'h5F, 8'h0F);
    chk(thermalThreshold, 2'h3);
    chk(thermalRolloffAmount, 2'h3);
    @(negedge clk) thermalHotIn = 1'b1;
    repeat (6) @(negedge clk);
    chk(thermalRolloffActive, 1'b1);
    thermalHotIn = 1'b0;
    repeat (6) @(negedge clk);
    chk(thermalRolloffActive, 1'b0);
  endtask
  ////////////////////////////////////////
  task automatic completeRun;
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    numErrors++;
    completeRun;
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_defaults;
    t_burst;
    t_scan;
    t_pull;
    t_spread;
    t_current;
    t_detect;
    t_freq;
    t_reset;
    t_thermal;
    completeRun;
  end
endmodule // led_page1_regs_bench
